//--- rtl/pipm_pkg.sv
// Constants, types and register map of the pin interrupt and pattern match unit
//----------------------------------------------------------------
// What this block does
// - Slice 6 condition lives in config bits 28:26, reset zero.
// - Slice 7 condition lives in config bits 31:29, reset zero.
// - Code 0x0: slice always contributes to its product term.
// - Code 0x1: match once a rising edge seen since last clear.
// - Code 0x2: match once a falling edge seen since last clear.
// - Code 0x3: match once any edge seen since last clear.
// - Sticky edges clear only on config or source-select writes.
// - Code 0x4: match while the selected input is high.
// - Code 0x5: match while the selected input is low.
// - Code 0x6: slice never matches.
// - Code 0x7: one-cycle match on any new edge.
// - Up to eight interrupt pins, each chosen by its own select register.
// - Pin interrupt registers are eight bits, bit n for select n.
// - Sense mode register picks edge or level per pin.
// - Rise and fall registers latch edges; writes clear and set them.
// - Status shows pending requests per pin; writes clear edge requests.
// - First enable: rise or level; second: fall or active level.
// - Set/clear-first writes set or clear first enable bits.
// - Edge pins: set/clear-second writes enable or disable falling edge.
// - Level pins: set/clear-second writes select high or low active.
// - Slice 7 is always an endpoint; others by their endpoint bit.
// - Pattern select bit routes product terms onto the pin interrupts.
//----------------------------------------------------------------
package pipm_pkg;

   localparam int unsigned PIN_COUNT = 32;
   localparam int unsigned SEL_W     = 5;
   localparam int unsigned CH        = 8;
   localparam int unsigned COND_W    = 3;
   localparam int unsigned ADDR_W    = 32;
   localparam int unsigned DATA_W    = 32;

   //----------------------------------------------------------------
   // Register offsets
   //----------------------------------------------------------------
   localparam logic [31:0] OFF_SENSE  = 32'hA000_4000;
   localparam logic [31:0] OFF_EN1    = 32'hA000_4004;
   localparam logic [31:0] OFF_SET1   = 32'hA000_4008;
   localparam logic [31:0] OFF_CLR1   = 32'hA000_400C;
   localparam logic [31:0] OFF_EN2    = 32'hA000_4010;
   localparam logic [31:0] OFF_SET2   = 32'hA000_4014;
   localparam logic [31:0] OFF_CLR2   = 32'hA000_4018;
   localparam logic [31:0] OFF_RISE   = 32'hA000_401C;
   localparam logic [31:0] OFF_FALL   = 32'hA000_4020;
   localparam logic [31:0] OFF_STATUS = 32'hA000_4024;
   localparam logic [31:0] OFF_PMCTL  = 32'hA000_4028;
   localparam logic [31:0] OFF_SRC    = 32'hA000_402C;
   localparam logic [31:0] OFF_CFG    = 32'hA000_4030;
   localparam logic [31:0] OFF_PSEL0  = 32'hA000_4040;

   //----------------------------------------------------------------
   // Field layout
   //----------------------------------------------------------------
   localparam int unsigned ENDPT_W     = 7;
   localparam int unsigned COND_LSB    = 8;
   localparam int unsigned SLICE6_CONDITION_LSB    = 26;
   localparam int unsigned SLICE7_CONDITION_LSB    = 29;
   localparam int unsigned SRC_LSB     = 8;
   localparam int unsigned PMCTL_SEL   = 0;
   localparam int unsigned PMCTL_TERMS = 24;
   localparam int unsigned PSEL_IDX_LSB = 2;
   localparam int unsigned PSEL_BLK_LSB = 5;

   //----------------------------------------------------------------
   // Condition codes
   //----------------------------------------------------------------
   localparam logic [2:0] COND_HIGH  = 3'h0;
   localparam logic [2:0] COND_RISE  = 3'h1;
   localparam logic [2:0] COND_FALL  = 3'h2;
   localparam logic [2:0] COND_EDGE  = 3'h3;
   localparam logic [2:0] COND_LVLH  = 3'h4;
   localparam logic [2:0] COND_LVLL  = 3'h5;
   localparam logic [2:0] COND_NEVER = 3'h6;
   localparam logic [2:0] COND_EVENT = 3'h7;

   //----------------------------------------------------------------
   // Types
   //----------------------------------------------------------------
   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic              wr;
      logic              rd;
   } pipm_bus_type;

   typedef struct packed {
      logic [PIN_COUNT-1:0]    pin_meta;
      logic [PIN_COUNT-1:0]    pin_sync;
      logic [CH-1:0]           sel_prev;
      logic [CH-1:0]           sl_prev;
      logic [CH*SEL_W-1:0]     pin_sel;
      logic [CH-1:0]           sense;
      logic [CH-1:0]           en1;
      logic [CH-1:0]           en2;
      logic [CH-1:0]           rise;
      logic [CH-1:0]           fall;
      logic [CH-1:0]           stk_r;
      logic [CH-1:0]           stk_f;
      logic [CH-1:0]           irq;
      logic                    pm_sel;
      logic [CH*COND_W-1:0]    src;
      logic [CH*COND_W-1:0]    cond;
      logic [ENDPT_W-1:0]      endpt;
      logic [DATA_W-1:0]       rdata;
   } pipm_state_type;

   localparam pipm_state_type STATE_RESET = '0;

endpackage

//--- rtl/pipm_top.sv
// Pin interrupt and pattern match unit with plain register port
`timescale 1ns/1ps
module pipm_top (
   // Clock and reset
   input  wire logic                           clk_sys,
   input  wire logic                           rst_n,
   // Register port
   input  wire pipm_pkg::pipm_bus_type         bus_req,
   output logic [pipm_pkg::DATA_W-1:0]         bus_rdata,
   // Device pins
   input  wire logic [pipm_pkg::PIN_COUNT-1:0] pins_in,
   // Interrupt requests to the processor
   output logic [pipm_pkg::CH-1:0]             pin_irq
);

   localparam int unsigned CH = pipm_pkg::CH;
   localparam int unsigned SW = pipm_pkg::SEL_W;
   localparam int unsigned CW = pipm_pkg::COND_W;

   pipm_pkg::pipm_state_type s_r;
   pipm_pkg::pipm_state_type s_nxt;

   logic [CH-1:0]     sel_in;
   logic [CH-1:0]     rise_ev;
   logic [CH-1:0]     fall_ev;
   logic [CH-1:0]     sl_in;
   logic [CH-1:0]     sl_rise;
   logic [CH-1:0]     sl_fall;
   logic [CH-1:0]     sl_match;
   logic [CH-1:0]     endpt;
   logic [CH-1:0]     term;
   logic [CH-1:0]     status;
   logic [CW-1:0]     cond [CH];
   logic              acc;
   logic              wr_sense;
   logic              wr_en1;
   logic              wr_set1;
   logic              wr_clr1;
   logic              wr_en2;
   logic              wr_set2;
   logic              wr_clr2;
   logic              wr_rise;
   logic              wr_fall;
   logic              wr_stat;
   logic              wr_pmctl;
   logic              wr_src;
   logic              wr_cfg;
   logic              psel_hit;
   logic [2:0]        psel_idx;
   logic [CH-1:0]     wd8;

   //----------------------------------------------------------------
   // Address decode
   //----------------------------------------------------------------
   assign wd8      = bus_req.wdata[CH-1:0];
   assign wr_sense = bus_req.wr && bus_req.addr == pipm_pkg::OFF_SENSE;
   assign wr_en1   = bus_req.wr && bus_req.addr == pipm_pkg::OFF_EN1;
   assign wr_set1  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_SET1;
   assign wr_clr1  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_CLR1;
   assign wr_en2   = bus_req.wr && bus_req.addr == pipm_pkg::OFF_EN2;
   assign wr_set2  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_SET2;
   assign wr_clr2  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_CLR2;
   assign wr_rise  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_RISE;
   assign wr_fall  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_FALL;
   assign wr_stat  = bus_req.wr && bus_req.addr == pipm_pkg::OFF_STATUS;
   assign wr_pmctl = bus_req.wr && bus_req.addr == pipm_pkg::OFF_PMCTL;
   assign wr_src   = bus_req.wr && bus_req.addr == pipm_pkg::OFF_SRC;
   assign wr_cfg   = bus_req.wr && bus_req.addr == pipm_pkg::OFF_CFG;
   assign psel_hit = bus_req.addr[pipm_pkg::ADDR_W-1:pipm_pkg::PSEL_BLK_LSB]
                     == pipm_pkg::OFF_PSEL0[pipm_pkg::ADDR_W-1:pipm_pkg::PSEL_BLK_LSB]
                     && bus_req.addr[1:0] == 2'h0;
   assign psel_idx = bus_req.addr[pipm_pkg::PSEL_IDX_LSB +: 3];

   //----------------------------------------------------------------
   // Derived detection and matching
   //----------------------------------------------------------------
   always_comb begin
      for (int i = 0; i < CH; i++) begin
         // Only the synchronised copy is sampled
         sel_in[i] = s_r.pin_sync[s_r.pin_sel[i*SW +: SW]];
      end
      rise_ev = sel_in & ~s_r.sel_prev;
      fall_ev = ~sel_in & s_r.sel_prev;
      for (int i = 0; i < CH; i++) begin
         sl_in[i] = sel_in[s_r.src[i*CW +: CW]];
         cond[i]  = s_r.cond[i*CW +: CW];
      end
      sl_rise = sl_in & ~s_r.sl_prev;
      sl_fall = ~sl_in & s_r.sl_prev;
      for (int i = 0; i < CH; i++) begin
         unique case (cond[i])
            pipm_pkg::COND_HIGH:  sl_match[i] = 1'b1;
            pipm_pkg::COND_RISE:  sl_match[i] = s_r.stk_r[i];
            pipm_pkg::COND_FALL:  sl_match[i] = s_r.stk_f[i];
            pipm_pkg::COND_EDGE:  sl_match[i] = s_r.stk_r[i] | s_r.stk_f[i];
            pipm_pkg::COND_LVLH:  sl_match[i] = sl_in[i];
            pipm_pkg::COND_LVLL:  sl_match[i] = ~sl_in[i];
            pipm_pkg::COND_NEVER: sl_match[i] = 1'b0;
            pipm_pkg::COND_EVENT: sl_match[i] = sl_rise[i] | sl_fall[i];
         endcase
      end
      // Slice 7 closes the last term unconditionally
      endpt = {1'b1, s_r.endpt};
      acc   = 1'b1;
      for (int i = 0; i < CH; i++) begin
         acc     = acc & sl_match[i];
         term[i] = endpt[i] & acc;
         if (endpt[i]) begin
            acc = 1'b1;
         end
      end
      for (int i = 0; i < CH; i++) begin
         if (s_r.sense[i]) begin
            // Level: first enable gates, second picks active level
            status[i] = s_r.en1[i] & ~(sel_in[i] ^ s_r.en2[i]);
         end else begin
            status[i] = (s_r.rise[i] & s_r.en1[i]) | (s_r.fall[i] & s_r.en2[i]);
         end
      end
   end

   //----------------------------------------------------------------
   // Next state
   //----------------------------------------------------------------
   always_comb begin
      s_nxt          = s_r;
      s_nxt.pin_meta = pins_in;
      s_nxt.pin_sync = s_r.pin_meta;
      s_nxt.sel_prev = sel_in;
      s_nxt.sl_prev  = sl_in;

      if (wr_sense) begin
         s_nxt.sense = wd8;
      end
      if (wr_en1) begin
         s_nxt.en1 = wd8;
      end else if (wr_set1) begin
         s_nxt.en1 = s_r.en1 | wd8;
      end else if (wr_clr1) begin
         s_nxt.en1 = s_r.en1 & ~wd8;
      end
      if (wr_en2) begin
         s_nxt.en2 = wd8;
      end else if (wr_set2) begin
         s_nxt.en2 = s_r.en2 | wd8;
      end else if (wr_clr2) begin
         s_nxt.en2 = s_r.en2 & ~wd8;
      end

      // Writes load the edge latches; a new edge wins
      if (wr_rise) begin
         s_nxt.rise = wd8;
      end else if (wr_stat) begin
         s_nxt.rise = s_r.rise & ~(wd8 & ~s_r.sense);
      end
      if (wr_fall) begin
         s_nxt.fall = wd8;
      end else if (wr_stat) begin
         s_nxt.fall = s_r.fall & ~(wd8 & ~s_r.sense);
      end
      s_nxt.rise = s_nxt.rise | rise_ev;
      s_nxt.fall = s_nxt.fall | fall_ev;

      if (wr_pmctl) begin
         s_nxt.pm_sel = bus_req.wdata[pipm_pkg::PMCTL_SEL];
      end
      if (wr_src) begin
         s_nxt.src = bus_req.wdata[pipm_pkg::SRC_LSB +: CH*CW];
      end
      if (wr_cfg) begin
         s_nxt.endpt = bus_req.wdata[pipm_pkg::ENDPT_W-1:0];
         s_nxt.cond  = bus_req.wdata[pipm_pkg::COND_LSB +: CH*CW];
      end
      if (psel_hit && bus_req.wr) begin
         s_nxt.pin_sel[psel_idx*SW +: SW] = bus_req.wdata[SW-1:0];
      end

      // Sticky edges: only these two writes clear, an edge wins
      s_nxt.stk_r = ((wr_cfg || wr_src) ? '0 : s_r.stk_r) | sl_rise;
      s_nxt.stk_f = ((wr_cfg || wr_src) ? '0 : s_r.stk_f) | sl_fall;

      s_nxt.irq = s_r.pm_sel ? term : status;

      s_nxt.rdata = '0;
      if (bus_req.rd) begin
         if (psel_hit) begin
            s_nxt.rdata[SW-1:0] = s_r.pin_sel[psel_idx*SW +: SW];
         end else begin
            unique case (bus_req.addr)
               pipm_pkg::OFF_SENSE:  s_nxt.rdata[CH-1:0] = s_r.sense;
               pipm_pkg::OFF_EN1:    s_nxt.rdata[CH-1:0] = s_r.en1;
               pipm_pkg::OFF_EN2:    s_nxt.rdata[CH-1:0] = s_r.en2;
               pipm_pkg::OFF_RISE:   s_nxt.rdata[CH-1:0] = s_r.rise;
               pipm_pkg::OFF_FALL:   s_nxt.rdata[CH-1:0] = s_r.fall;
               pipm_pkg::OFF_STATUS: s_nxt.rdata[CH-1:0] = status;
               pipm_pkg::OFF_PMCTL: begin
                  s_nxt.rdata[pipm_pkg::PMCTL_SEL]        = s_r.pm_sel;
                  s_nxt.rdata[pipm_pkg::PMCTL_TERMS +: CH] = term;
               end
               pipm_pkg::OFF_SRC:    s_nxt.rdata[pipm_pkg::SRC_LSB +: CH*CW] = s_r.src;
               pipm_pkg::OFF_CFG: begin
                  s_nxt.rdata[pipm_pkg::ENDPT_W-1:0]       = s_r.endpt;
                  s_nxt.rdata[pipm_pkg::COND_LSB +: CH*CW] = s_r.cond;
               end
               default:              s_nxt.rdata = '0;
            endcase
         end
      end
   end

   //----------------------------------------------------------------
   // State register
   //----------------------------------------------------------------
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         s_r <= pipm_pkg::STATE_RESET;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign bus_rdata = s_r.rdata;
   assign pin_irq   = s_r.irq;

   //----------------------------------------------------------------
   // Assertions
   //----------------------------------------------------------------
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);

   sequence seq_slice_clear;
      wr_cfg || wr_src;
   endsequence

   sequence seq_cfg_read;
      bus_req.rd && bus_req.addr == pipm_pkg::OFF_CFG;
   endsequence

   a_cond6_field: assert property (
      wr_cfg |=> cond[6] == $past(bus_req.wdata[pipm_pkg::SLICE6_CONDITION_LSB +: 3]))
      else $error("slice 6 condition field not loaded");

   a_cond7_field: assert property (
      seq_cfg_read |=> bus_rdata[pipm_pkg::SLICE7_CONDITION_LSB +: 3] == $past(cond[7]))
      else $error("slice 7 condition readback wrong");

   a_const_high: assert property (
      cond[6] == pipm_pkg::COND_HIGH |-> sl_match[6])
      else $error("constant high slice not matching");

   a_sticky_rise: assert property (
      cond[6] == pipm_pkg::COND_RISE && sl_rise[6] && !wr_cfg && !wr_src
      ##1 cond[6] == pipm_pkg::COND_RISE |-> sl_match[6])
      else $error("sticky rise not reported");

   a_sticky_fall: assert property (
      cond[6] == pipm_pkg::COND_FALL && sl_fall[6] && !wr_cfg && !wr_src
      ##1 cond[6] == pipm_pkg::COND_FALL |-> sl_match[6])
      else $error("sticky fall not reported");

   a_sticky_any: assert property (
      cond[7] == pipm_pkg::COND_EDGE |-> sl_match[7] == (s_r.stk_r[7] | s_r.stk_f[7]))
      else $error("sticky any edge wrong");

   a_sticky_hold: assert property (
      s_r.stk_r[6] && !wr_cfg && !wr_src |=> s_r.stk_r[6])
      else $error("sticky edge lost without clearing write");

   a_sticky_clear: assert property (
      seq_slice_clear and !sl_fall[7] |=> !s_r.stk_f[7])
      else $error("sticky edge not cleared by write");

   a_level_high: assert property (
      cond[7] == pipm_pkg::COND_LVLH |-> sl_match[7] == sel_in[s_r.src[7*CW +: CW]])
      else $error("high level match wrong");

   a_level_low: assert property (
      cond[6] == pipm_pkg::COND_LVLL && $stable(sl_in[6]) |-> sl_match[6] != sl_in[6])
      else $error("low level match wrong");

   a_never: assert property (
      cond[7] == pipm_pkg::COND_NEVER |-> !sl_match[7])
      else $error("disabled slice matched");

   a_event_pulse: assert property (
      cond[7] == pipm_pkg::COND_EVENT && $stable(cond[7]) |-> sl_match[7] == $changed(sl_in[7]))
      else $error("event match not a one-cycle edge pulse");

   a_sync_delay: assert property (
      $changed(pins_in[0]) ##1 $stable(pins_in[0]) |=> s_r.pin_sync[0] == $past(pins_in[0], 2))
      else $error("pin synchroniser depth wrong");

   a_set_first: assert property (
      wr_set1 && wd8[2] |=> s_r.en1[2])
      else $error("set first enable failed");

   a_clear_second: assert property (
      wr_clr2 && wd8[2] |=> !s_r.en2[2] ##1 (!s_r.en2[2] || $past(wr_en2) || $past(wr_set2)))
      else $error("clear second enable failed");

   a_level_irq: assert property (
      !s_r.pm_sel && s_r.sense[2] && s_r.en1[2] && s_r.en2[2] && sel_in[2] |=> pin_irq[2])
      else $error("high-active level request missing");

   a_rise_latch: assert property (
      rise_ev[1] |=> s_r.rise[1])
      else $error("rising edge not latched");

   a_edge_irq: assert property (
      !s_r.pm_sel && !s_r.sense[2] && s_r.rise[2] && s_r.en1[2] |=> pin_irq[2])
      else $error("edge request missing");

   a_pm_route: assert property (
      s_r.pm_sel |=> pin_irq == $past(term))
      else $error("product terms not routed to pin interrupts");

   a_end_seven: assert property (
      &sl_match |-> term[7])
      else $error("slice 7 not an endpoint");

   a_read_once: assert property (
      !bus_req.rd |=> bus_rdata == '0)
      else $error("read data outside its cycle");

   a_status_clear: assert property (
      wr_stat && !s_r.sense[2] && wd8[2] && !rise_ev[2] && !fall_ev[2] |=> !s_r.rise[2] && !s_r.fall[2])
      else $error("status write did not clear edge request");

   a_status_level: assert property (
      wr_stat && s_r.sense[2] |=> s_r.rise[2] == $past(s_r.rise[2] | rise_ev[2]))
      else $error("status write disturbed a level pin");

   a_fall_latch: assert property (
      fall_ev[2] |=> s_r.fall[2])
      else $error("falling edge not latched");

   a_rise_write: assert property (
      wr_rise |=> s_r.rise == ($past(wd8) | $past(rise_ev)))
      else $error("rise latch write not loaded");

   a_clear_first: assert property (
      wr_clr1 |=> (s_r.en1 & $past(wd8)) == 8'h00)
      else $error("clear first enable failed");

   a_set_second: assert property (
      wr_set2 |=> (s_r.en2 & $past(wd8)) == $past(wd8))
      else $error("set second enable failed");

   a_low_level_irq: assert property (
      !s_r.pm_sel && s_r.sense[2] && s_r.en1[2] && !s_r.en2[2] && !sel_in[2] |=> pin_irq[2])
      else $error("low-active level request missing");

   a_level_gate: assert property (
      !s_r.pm_sel && s_r.sense[2] && !s_r.en1[2] |=> !pin_irq[2])
      else $error("disabled level pin requested");

   a_sense_write: assert property (
      wr_sense |=> s_r.sense == $past(wd8))
      else $error("sense mode write not loaded");

   a_psel_write: assert property (
      psel_hit && bus_req.wr |=> s_r.pin_sel[$past(psel_idx)*SW +: SW] == $past(bus_req.wdata[SW-1:0]))
      else $error("pin select write not loaded");

   a_normal_route: assert property (
      !s_r.pm_sel |=> pin_irq == $past(status))
      else $error("pin requests not routed to pin interrupts");

   a_status_read: assert property (
      bus_req.rd && bus_req.addr == pipm_pkg::OFF_STATUS |=> bus_rdata == {24'h00_0000, $past(status)})
      else $error("status readback wrong");

endmodule // pipm_top

//--- tb/pipm_pin_model.sv
// Driver model of the device pins outside the block
`timescale 1ns/1ps
module pipm_pin_model (
   // Clock
   input  wire logic        clk_sys,
   // Levels requested by the bench
   input  wire logic [31:0] pin_cmd,
   // Pins towards the block
   output logic [31:0]      pins_out
);
   //----------------------------------------------------------------
   // Pins move only just after a clock edge, never mid-cycle
   //----------------------------------------------------------------
   initial pins_out = '0;
   always @(posedge clk_sys) begin
      pins_out <= pin_cmd;
   end
endmodule // pipm_pin_model

//--- tb/pipm_top_tb.sv
// Register-level testbench of the pin interrupt and pattern match unit
`timescale 1ns/1ps
module pipm_top_tb;
   localparam logic [31:0] B2 = 32'h0000_0004;
   logic                   clk_sys;
   logic                   rst_n;
   pipm_pkg::pipm_bus_type bus_req;
   logic [31:0]            bus_rdata;
   logic [31:0]            pins_in;
   logic [7:0]             pin_irq;
   logic [31:0]            pin_cmd;
   int                     failures;
   int                     n_checks;

   pipm_top dut (.clk_sys(clk_sys), .rst_n(rst_n), .bus_req(bus_req), .bus_rdata(bus_rdata),
                 .pins_in(pins_in), .pin_irq(pin_irq));
   pipm_pin_model pins (.clk_sys(clk_sys), .pin_cmd(pin_cmd), .pins_out(pins_in));

   always #50 clk_sys = ~clk_sys;

   //----------------------------------------------------------------
   // Access and check tasks
   //----------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic wr(input logic [31:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_sys);
      bus_req <= '0;
   endtask

   task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
      @(posedge clk_sys);
      bus_req <= '{addr: a, wdata: 32'h0000_0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_sys);
      bus_req <= '0;
      #1;
      chk(bus_rdata, exp);
   endtask

   task automatic settle(input int n);
      repeat (n) @(posedge clk_sys);
      #1;
   endtask

   task automatic irq(input int n, input logic e);
      settle(8);
      chk({31'h0, pin_irq[n]}, {31'h0, e});
   endtask

   // Slice 7 term under config c, pin 0 driven to p1 then p2
   task automatic pm(input logic [31:0] c, input logic p1, input logic e1, input logic p2, input logic e2);
      wr(pipm_pkg::OFF_CFG, c);
      pin_cmd[0] <= p1;
      irq(7, e1);
      pin_cmd[0] <= p2;
      irq(7, e2);
   endtask

   task automatic print_verdict;
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   initial begin
      #5_000_000;
      failures++;
      print_verdict;
   end

   //----------------------------------------------------------------
   // Main sequence
   //----------------------------------------------------------------
   initial begin
      int n;
      clk_sys = 1'b0;
      rst_n = 1'b0;
      bus_req = '0;
      pin_cmd = '0;
      failures = 0;
      n_checks = 0;
      repeat (5) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(pipm_pkg::OFF_CFG, 32'h0000_0000);
      rdc(pipm_pkg::OFF_EN1, 32'h0000_0000);
      rdc(pipm_pkg::OFF_STATUS, 32'h0000_0000);
      rdc(32'hA000_4060, 32'h0000_0000);
      wr(pipm_pkg::OFF_CFG, 32'hE400_0000);
      rdc(pipm_pkg::OFF_CFG, 32'hE400_0000);
      wr(pipm_pkg::OFF_CFG, 32'h0000_0000);
      $display("test reset and map done");

      wr(pipm_pkg::OFF_PSEL0 + 32'h0000_0008, 32'h0000_0003);
      wr(pipm_pkg::OFF_SET1, B2);
      rdc(pipm_pkg::OFF_EN1, B2);
      pin_cmd[3] <= 1'b1;
      irq(2, 1'b1);
      rdc(pipm_pkg::OFF_RISE, B2);
      wr(pipm_pkg::OFF_STATUS, B2);
      irq(2, 1'b0);
      wr(pipm_pkg::OFF_RISE, B2);
      rdc(pipm_pkg::OFF_RISE, B2);
      wr(pipm_pkg::OFF_RISE, 32'h0000_0000);
      rdc(pipm_pkg::OFF_RISE, 32'h0000_0000);
      wr(pipm_pkg::OFF_CLR1, B2);
      rdc(pipm_pkg::OFF_EN1, 32'h0000_0000);
      wr(pipm_pkg::OFF_SET2, B2);
      rdc(pipm_pkg::OFF_EN2, B2);
      pin_cmd[3] <= 1'b0;
      irq(2, 1'b1);
      rdc(pipm_pkg::OFF_FALL, B2);
      wr(pipm_pkg::OFF_STATUS, B2);
      wr(pipm_pkg::OFF_CLR2, B2);
      rdc(pipm_pkg::OFF_EN2, 32'h0000_0000);
      pin_cmd[3] <= 1'b1;
      settle(8);
      pin_cmd[3] <= 1'b0;
      irq(2, 1'b0);
      $display("test edge pins done");

      wr(pipm_pkg::OFF_SENSE, B2);
      wr(pipm_pkg::OFF_SET1, B2);
      wr(pipm_pkg::OFF_SET2, B2);
      pin_cmd[3] <= 1'b1;
      irq(2, 1'b1);
      wr(pipm_pkg::OFF_STATUS, B2);
      irq(2, 1'b1);
      wr(pipm_pkg::OFF_CLR2, B2);
      irq(2, 1'b0);
      pin_cmd[3] <= 1'b0;
      irq(2, 1'b1);
      wr(pipm_pkg::OFF_CLR1, B2);
      irq(2, 1'b0);
      wr(pipm_pkg::OFF_SENSE, 32'h0000_0000);
      $display("test level pins done");

      wr(pipm_pkg::OFF_PMCTL, 32'h0000_0001);
      rdc(pipm_pkg::OFF_PMCTL, 32'h8000_0001);
      pm(32'h0000_0000, 1'b0, 1'b1, 1'b1, 1'b1);
      pm(32'h8000_0000, 1'b1, 1'b1, 1'b0, 1'b0);
      pm(32'hA000_0000, 1'b1, 1'b0, 1'b0, 1'b1);
      pm(32'hC000_0000, 1'b1, 1'b0, 1'b0, 1'b0);
      pm(32'h2000_0000, 1'b1, 1'b1, 1'b0, 1'b1);
      wr(pipm_pkg::OFF_SRC, 32'h0000_0000);
      irq(7, 1'b0);
      pm(32'h4000_0000, 1'b1, 1'b0, 1'b0, 1'b1);
      pm(32'h6000_0000, 1'b1, 1'b1, 1'b0, 1'b1);
      pm(32'h1800_0000, 1'b1, 1'b0, 1'b0, 1'b0);
      pm(32'h0400_0000, 1'b1, 1'b1, 1'b0, 1'b1);
      pm(32'h0800_0000, 1'b1, 1'b0, 1'b0, 1'b1);
      pm(32'h1400_0000, 1'b1, 1'b0, 1'b0, 1'b1);
      pm(32'h0000_0600, 1'b1, 1'b0, 1'b0, 1'b0);
      pm(32'h0000_0601, 1'b1, 1'b1, 1'b0, 1'b1);
      irq(0, 1'b0);
      wr(pipm_pkg::OFF_CFG, 32'hE000_0000);
      for (int k = 0; k < 2; k++) begin
         n = 0;
         pin_cmd[0] <= ~pin_cmd[0];
         repeat (10) begin
            @(posedge clk_sys);
            #1;
            if (pin_irq[7] === 1'b1)
               n++;
         end
         chk(n, 32'h0000_0001);
      end
      $display("test pattern match done");
      print_verdict;
   end
endmodule // pipm_top_tb
